// ==== hdl/sac_pkg.sv ====
// Shared constants for the serial successive-approximation sequencer
package sac_pkg;

  // Word geometry
  localparam int          SAR_W          = 10;
  localparam int          POS_W          = 4;
  localparam logic [3:0]  POS_MSB        = 4'h9;
  localparam logic [3:0]  POS_LSB        = 4'h0;
  localparam logic [3:0]  POS_SHORT_LSB  = 4'h2;
  localparam logic [9:0]  SAR_MSB_MASK   = 10'h200;
  localparam logic [9:0]  SAR_RST        = 10'h000;

  // Result buffer shape
  localparam int          FIFO_DEPTH     = 8;

  // Timing
  localparam int          CLK_PERIOD_NS  = 20;
  localparam int          FLAG_MAX_NS    = 150;
  localparam int          FLAG_MAX_CYC   = (FLAG_MAX_NS / CLK_PERIOD_NS) < 1 ? 1
                                         : (FLAG_MAX_NS / CLK_PERIOD_NS);
  localparam int          HALF_BIT_NS    = 900;
  localparam int          HALF_BIT_CYC   = (HALF_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          DIV_W          = 6;

  // Pin synchroniser lanes and their reset levels
  localparam int          SYN_N          = 6;
  localparam int          SYN_START      = 0;
  localparam int          SYN_SHORT_CYCLE_TERMINATE_N       = 1;
  localparam int          SYN_CLKSEL     = 2;
  localparam int          SYN_CMP        = 3;
  localparam int          SYN_XRISE      = 4;
  localparam int          SYN_XFALL      = 5;
  localparam logic [5:0]  SYN_RST        = 6'h02;

  // Output reset levels
  localparam logic        DOUT_N_RST     = 1'b1;
  localparam logic        BCO_RST        = 1'b0;
  localparam logic        BUSY_RST       = 1'b0;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_RUN  = 2'b01,
    S_TAIL = 2'b10
  } sac_state_e;

endpackage : sac_pkg

// ==== hdl/sac_sequencer.sv ====
// Serial successive-approximation sequencer with result buffer
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module sac_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             resetn_in,
  // Fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              push = in_valid_in && in_ready_out;
  wire              pop  = out_valid_out && out_ready_in;

  assign in_ready_out  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out  = mem_q[rd_q];

  // Storage has no reset; only words below the count are ever shown
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem_q[wr_q] <= in_data_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= push ? AW'(wr_q + 1'b1) : wr_q;
      rd_q  <= pop ? AW'(rd_q + 1'b1) : rd_q;
      cnt_q <= (AW+1)'(cnt_q + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0));
    end
  end

endmodule : sac_fifo

////////////////////////////////////////////////////////////////////////////////
module sac_sequencer (
  // System clock and reset
  input  wire logic                      clk_sys_in,
  input  wire logic                      resetn_in,
  // Link clock from the far side
  input  wire logic                      external_clock_in,
  // Control pins
  input  wire logic                      conversion_start_in,
  input  wire logic                      short_cycle_terminate_n,
  input  wire logic                      clock_source_select_n,
  // Comparator and trial word
  input  wire logic                      comparator_sum_below_in,
  output logic [sac_pkg::SAR_W-1:0]      sar_trial_out,
  // Serial link
  output logic                           bit_clock_out,
  output logic                           serial_data_n_out,
  output logic                           conversion_busy_out,
  // Buffered parallel results
  output logic                           result_valid_out,
  input  wire logic                      result_ready_in,
  output logic [sac_pkg::SAR_W-1:0]      result_data_out
);
  import sac_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Link domain: each edge of the external clock flips a toggle
  logic ext_rise_tgl_q;
  logic ext_fall_tgl_q;

  always_ff @(posedge external_clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ext_rise_tgl_q <= 1'b0;
    end else begin
      ext_rise_tgl_q <= ~ext_rise_tgl_q;
    end
  end

  always_ff @(negedge external_clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ext_fall_tgl_q <= 1'b0;
    end else begin
      ext_fall_tgl_q <= ~ext_fall_tgl_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Three-stage synchronisers; a change is taken once stages two and three agree
  wire  [SYN_N-1:0] raw_pins;
  logic [SYN_N-1:0] flt_q;
  logic [SYN_N-1:0] flt_prev_q;

  assign raw_pins[SYN_START]  = conversion_start_in;
  assign raw_pins[SYN_SHORT_CYCLE_TERMINATE_N]   = short_cycle_terminate_n;
  assign raw_pins[SYN_CLKSEL] = clock_source_select_n;
  assign raw_pins[SYN_CMP]    = comparator_sum_below_in;
  assign raw_pins[SYN_XRISE]  = ext_rise_tgl_q;
  assign raw_pins[SYN_XFALL]  = ext_fall_tgl_q;

  for (genvar i = 0; i < SYN_N; i++) begin : g_sync
    logic s1_q;
    logic s2_q;
    logic s3_q;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
        s1_q          <= SYN_RST[i];
        s2_q          <= SYN_RST[i];
        s3_q          <= SYN_RST[i];
        flt_q[i]      <= SYN_RST[i];
        flt_prev_q[i] <= SYN_RST[i];
      end else begin
        s1_q          <= raw_pins[i];
        s2_q          <= s1_q;
        s3_q          <= s2_q;
        flt_q[i]      <= (s2_q == s3_q) ? s3_q : flt_q[i];
        flt_prev_q[i] <= flt_q[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  sac_state_e         state_q, state_d;
  logic [SAR_W-1:0]   sar_q, sar_d;
  logic [POS_W-1:0]   pos_q, pos_d;
  logic               first_q, first_d;
  logic               busy_q, busy_d;
  logic               dout_n_q, dout_n_d;
  logic               bco_q, bco_d;
  logic               cont_q, cont_d;
  logic               term_q, term_d;
  logic [DIV_W-1:0]   div_q;
  logic               phase_q;
  logic               push;

  // Pin decode
  wire start_lvl   = flt_q[SYN_START];
  wire start_ev    = flt_q[SYN_START] && !flt_prev_q[SYN_START];
  wire short_cycle_terminate_n_lvl_n  = flt_q[SYN_SHORT_CYCLE_TERMINATE_N];
  wire short_cycle_terminate_n_fall   = !flt_q[SYN_SHORT_CYCLE_TERMINATE_N] && flt_prev_q[SYN_SHORT_CYCLE_TERMINATE_N];
  wire int_sel     = !flt_q[SYN_CLKSEL];
  wire cmp_below   = flt_q[SYN_CMP];
  wire running     = (state_q != S_IDLE);

  // Bit clock source: internal divider or external edges
  wire div_wrap    = running && (div_q == DIV_W'(HALF_BIT_CYC - 1));
  wire int_rise    = div_wrap && !phase_q;
  wire int_fall    = div_wrap && phase_q;
  wire ext_rise    = running && (flt_q[SYN_XRISE] != flt_prev_q[SYN_XRISE]);
  wire ext_fall    = running && (flt_q[SYN_XFALL] != flt_prev_q[SYN_XFALL]);
  wire tick_rise   = int_sel ? int_rise : ext_rise;
  wire tick_fall   = int_sel ? int_fall : ext_fall;

  // Trial decode
  wire [SAR_W-1:0] pos_mask   = SAR_W'(1) << pos_q;
  wire [POS_W-1:0] pos_next   = POS_W'(pos_q - 1'b1);
  wire [SAR_W-1:0] next_mask  = SAR_W'(1) << pos_next;
  wire             deciding   = (state_q == S_RUN) && tick_rise && !first_q;
  wire             final_bit  = (pos_q == POS_LSB) || term_q
                              || (!short_cycle_terminate_n_lvl_n && (pos_q == POS_SHORT_LSB));
  wire [SAR_W-1:0] kept_sar   = cmp_below ? sar_q : (sar_q & ~pos_mask);
  wire             fifo_ready;

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    state_d  = state_q;
    sar_d    = sar_q;
    pos_d    = pos_q;
    first_d  = first_q;
    busy_d   = busy_q;
    dout_n_d = dout_n_q;
    bco_d    = bco_q;
    cont_d   = cont_q;
    term_d   = term_q;
    push     = 1'b0;
    case (state_q)
      S_IDLE: begin
        bco_d = 1'b0;
        // A full buffer holds off new conversions rather than dropping words
        if (start_ev && fifo_ready) begin
          state_d = S_RUN;
          busy_d  = 1'b1;
          first_d = 1'b1;
          sar_d   = SAR_RST;
        end
      end
      S_RUN: begin
        if (tick_rise) begin
          bco_d = 1'b1;
          if (first_q) begin
            first_d = 1'b0;
            sar_d   = SAR_MSB_MASK;
            pos_d   = POS_MSB;
          end else begin
            sar_d    = kept_sar;
            dout_n_d = !cmp_below;
            if (final_bit) begin
              busy_d  = 1'b0;
              push    = 1'b1;
              cont_d  = start_lvl;
              term_d  = 1'b0;
              state_d = S_TAIL;
            end else begin
              pos_d = pos_next;
              sar_d = kept_sar | next_mask;
            end
          end
        end else if (tick_fall) begin
          bco_d = 1'b0;
        end
      end
      S_TAIL: begin
        // The extra pulse ends only on its own falling edge
        if (tick_fall) begin
          bco_d = 1'b0;
          if (cont_q && fifo_ready) begin
            state_d = S_RUN;
            busy_d  = 1'b1;
            first_d = 1'b1;
            sar_d   = SAR_RST;
          end else begin
            state_d = S_IDLE;
          end
        end
      end
      default: begin
        state_d = S_IDLE;
        busy_d  = 1'b0;
      end
    endcase
    // An early terminate edge wins over the end-of-word clear
    if (short_cycle_terminate_n_fall) begin
      term_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q  <= S_IDLE;
      sar_q    <= SAR_RST;
      pos_q    <= POS_MSB;
      first_q  <= 1'b0;
      busy_q   <= BUSY_RST;
      dout_n_q <= DOUT_N_RST;
      bco_q    <= BCO_RST;
      cont_q   <= 1'b0;
      term_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      sar_q    <= sar_d;
      pos_q    <= pos_d;
      first_q  <= first_d;
      busy_q   <= busy_d;
      dout_n_q <= dout_n_d;
      bco_q    <= bco_d;
      cont_q   <= cont_d;
      term_q   <= term_d;
    end
  end

  // Internal bit clock divider runs only while the sequencer is out of S_IDLE, tail pulse included
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      div_q   <= '0;
      phase_q <= 1'b0;
    end else begin
      div_q   <= (!running || div_wrap) ? '0 : DIV_W'(div_q + 1'b1);
      phase_q <= running && (div_wrap ? !phase_q : phase_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Result buffer; words are stored negative-true as shifted out
  wire [SAR_W-1:0] result_word = ~kept_sar;

  sac_fifo #(
    .WIDTH (SAR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in    (clk_sys_in),
    .resetn_in     (resetn_in),
    .in_valid_in   (push),
    .in_ready_out  (fifo_ready),
    .in_data_in    (result_word),
    .out_valid_out (result_valid_out),
    .out_ready_in  (result_ready_in),
    .out_data_out  (result_data_out)
  );

  assign sar_trial_out       = sar_q;
  assign bit_clock_out       = bco_q;
  assign serial_data_n_out   = dout_n_q;
  assign conversion_busy_out = busy_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  localparam int FLAG_BOUND = FLAG_MAX_CYC;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);

  sequence seq_decide;
    (state_q == S_RUN) && tick_rise && !first_q;
  endsequence

  sequence seq_last;
    seq_decide ##0 final_bit;
  endsequence

  AST_START_FLAG: assert property (
    $rose(conversion_start_in) && (state_q == S_IDLE) && fifo_ready
      && !flt_q[SYN_START] |-> ##[1:FLAG_BOUND] conversion_busy_out)
    else $error("busy flag late after start");

  AST_MSB_FIRST: assert property (
    (state_q == S_RUN) && tick_rise && first_q
      |=> (sar_trial_out == SAR_MSB_MASK) && (pos_q == POS_MSB))
    else $error("first trial is not the top bit");

  AST_KEEP_LOW: assert property (
    seq_decide ##0 cmp_below |=> !serial_data_n_out && ((sar_q & $past(pos_mask)) != '0))
    else $error("kept bit not shown low");

  AST_CLEAR_HIGH: assert property (
    seq_decide ##0 !cmp_below |=> serial_data_n_out && ((sar_q & $past(pos_mask)) == '0))
    else $error("cleared bit not shown high");

  AST_FLAG_FALL: assert property (
    seq_last |-> push ##1 !conversion_busy_out && (state_q == S_TAIL))
    else $error("flag not dropped after last decision");

  AST_SHORT_8: assert property (
    seq_decide ##0 (!short_cycle_terminate_n_lvl_n && (pos_q == POS_SHORT_LSB)) |=> !conversion_busy_out)
    else $error("short cycle did not end at eighth bit");

  AST_CONT_RISE: assert property (
    (state_q == S_TAIL) && cont_q && fifo_ready && tick_fall
      |=> conversion_busy_out && first_q && !bit_clock_out)
    else $error("continuous flag did not rise at falling edge");

  AST_TAIL_LOW: assert property (
    (state_q == S_TAIL) && !tick_fall |=> !conversion_busy_out)
    else $error("flag rose before bit clock fell");

  AST_TAIL_FULL: assert property (
    seq_last |=> bit_clock_out throughout (state_q == S_TAIL) [*2])
    else $error("extra pulse shortened");

  AST_DOUT_STABLE: assert property (
    !deciding |=> $stable(serial_data_n_out))
    else $error("serial bit changed between rising edges");

  AST_IDLE_STOP: assert property (
    (state_q == S_TAIL) && !cont_q && tick_fall |=> (state_q == S_IDLE) && !conversion_busy_out)
    else $error("triggered mode did not stop");

endmodule : sac_sequencer

`default_nettype wire

// ==== dv/sac_host_model.sv ====
// Far-side model: comparator front end and serial word receiver
`timescale 1ns/1ps
`default_nettype none
module sac_host_model (
  // Clock
  input  wire logic       clk_sys_in,
  // Analog stand-in and expected word length
  input  wire logic [9:0] vin_in,
  input  wire logic [3:0] nbits_in,
  // Device side
  input  wire logic [9:0] trial_in,
  input  wire logic       bco_in,
  input  wire logic       sdn_in,
  output logic            cmp_out,
  // Received word
  output var logic        rx_done_out,
  output var logic [9:0]  rx_word_out
);
  logic       bco_q = 1'b0;
  logic [3:0] cnt_q = 4'h0;
  logic [9:0] sh_q  = 10'h000;

  // Trial kept while its sum does not exceed the input
  assign cmp_out = (trial_in <= vin_in);

  ////////////////////////////////////////////////////////////////////////////
  // Sampled on falling edges; the first fall of a word carries no data
  always @(posedge clk_sys_in) begin
    bco_q <= bco_in;
    rx_done_out <= 1'b0;
    if (bco_q && !bco_in) begin
      if (cnt_q == nbits_in) begin
        rx_word_out <= {sh_q[8:0], sdn_in};
        rx_done_out <= 1'b1;
        sh_q <= 10'h000;
        cnt_q <= 4'h0;
      end else begin
        if (cnt_q != 4'h0) sh_q <= {sh_q[8:0], sdn_in};
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule : sac_host_model
`default_nettype wire

// ==== dv/tb_sac_sequencer.sv ====
// Self-checking bench for the serial sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_sac_sequencer;
  import sac_pkg::*;
  logic       clk = 1'b0, rstn = 1'b0, xclk = 1'b0, ext = 1'b0, x_run = 1'b0;
  logic       start = 1'b0, short_cycle_terminate_n_n = 1'b1, sel_n = 1'b0, ready = 1'b1;
  logic       cmp, bco, sdn, busy, rvalid, rx_done;
  logic [9:0] trial, rdata, rx_word, vin = 10'h000;
  logic [3:0] nbits = 4'ha;
  logic       bco_q = 1'b0, busy_q = 1'b0, sdn_q = 1'b1, cont = 1'b0;
  int         num_errors = 0, total_checks = 0, pcnt = 0, hcnt = 0, xcnt = 0;
  logic [9:0] ser_q[$], res_q[$];
  logic [9:0] codes[5] = '{10'h001, 10'h3ff, 10'h200, 10'h000, 10'h155};

  initial begin
    forever #10 clk = ~clk;
  end
  // Offset start keeps link edges off the system clock edges
  initial begin
    #1;
    forever #6 xclk = ~xclk;
  end
  // Link oscillator divided to a slow bit clock; parks low between frames
  always @(posedge xclk) begin
    if (x_run || ext) begin
      xcnt <= (xcnt == 74) ? 0 : xcnt + 1;
      if (xcnt == 74) ext <= ~ext;
    end
  end

  sac_sequencer i_dut (
    .clk_sys_in(clk), .resetn_in(rstn), .external_clock_in(ext),
    .conversion_start_in(start), .short_cycle_terminate_n(short_cycle_terminate_n_n),
    .clock_source_select_n(sel_n), .comparator_sum_below_in(cmp),
    .sar_trial_out(trial), .bit_clock_out(bco), .serial_data_n_out(sdn),
    .conversion_busy_out(busy), .result_valid_out(rvalid),
    .result_ready_in(ready), .result_data_out(rdata));

  sac_host_model i_host (
    .clk_sys_in(clk), .vin_in(vin), .nbits_in(nbits), .trial_in(trial),
    .bco_in(bco), .sdn_in(sdn), .cmp_out(cmp), .rx_done_out(rx_done),
    .rx_word_out(rx_word));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  task automatic wait_busy(input logic lvl, input int lim, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (busy !== lvl && n <= lim);
  endtask : wait_busy

  // Short words read back with their unused low bits set
  task automatic expect_word();
    logic [9:0] w;
    w = ~vin;
    ser_q.push_back(w >> (10 - nbits));
    res_q.push_back(w | (10'h3ff >> nbits));
  endtask : expect_word

  task automatic convert(input int words, input bit hold, input bit keep);
    int n;
    @(posedge clk);
    start <= 1'b1;
    wait_busy(1'b1, 20, n);
    check("flag delay", 10'(n - 1 <= FLAG_MAX_CYC), 10'h001);
    if (!hold) begin
      repeat (16 - n) @(posedge clk);
      start <= 1'b0;
    end
    for (int i = 0; i < words; i++) begin
      if (i > 0) begin
        wait_busy(1'b1, 200, n);
        check("restart", 10'(n <= 200), 10'h001);
      end
      // Noted while the word is being built, long before it can surface
      expect_word();
      if (i == words - 1 && hold && !keep) start <= 1'b0;
      wait_busy(1'b0, 3000, n);
      check("conversion ends", 10'(n <= 3000), 10'h001);
      // Armed only after the first word, so a pin start is never taken as a restart
      cont = hold;
    end
    cont = 1'b0;
    while (bco !== 1'b0) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask : convert

  ////////////////////////////////////////////////////////////////////////////
  // Monitor: framing, pulse shape and the two result streams
  always @(posedge clk) begin
    if (rstn) begin
      if (bco && !bco_q) pcnt = pcnt + 1;
      if (busy && !busy_q) begin
        pcnt = 0;
        if (cont) begin
          check("restart on fall", {9'h0, bco_q && !bco}, 10'h001);
        end
      end
      if (!busy && busy_q) begin
        check("drop on rise", {9'h0, bco && !bco_q}, 10'h001);
        check("pulse count", 10'(pcnt), 10'(nbits) + 10'h001);
      end
      if (bco_q && !bco && !sel_n) begin
        check("pulse width", 10'(hcnt), 10'(HALF_BIT_CYC));
      end
      if (sdn !== sdn_q) begin
        check("data edge", {9'h0, bco && !bco_q}, 10'h001);
      end
      if (rx_done === 1'b1) begin
        check("serial word", rx_word, ser_q.pop_front());
      end
      if (rvalid === 1'b1 && ready) begin
        check("result", rdata, res_q.pop_front());
      end
    end
    hcnt = bco ? hcnt + 1 : 0;
    bco_q = bco;
    busy_q = busy;
    sdn_q = sdn;
  end

  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    print_verdict();
  end

  initial begin
    int n;
    void'($urandom(20));
    repeat (15) @(posedge clk);
    check("reset outputs", {6'h0, bco, sdn, busy, rvalid}, 10'h004);
    check("reset trial", trial, SAR_RST);
    @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    // Coding corners, then a random level
    codes[4] = 10'($urandom);
    foreach (codes[i]) begin
      vin <= codes[i];
      convert(1, 0, 0);
    end
    // Back-to-back stream
    vin <= 10'($urandom);
    convert(3, 1, 0);
    // Fill the buffer until restart is refused, then drain with a stalling reader
    ready <= 1'b0;
    vin <= 10'($urandom);
    convert(FIFO_DEPTH, 1, 1);
    wait_busy(1'b1, 2500, n);
    check("refused when full", 10'(n > 2500), 10'h001);
    start <= 1'b0;
    n = 0;
    while (res_q.size() > 0 && n < 400) begin
      @(posedge clk);
      ready <= 1'($urandom);
      n++;
    end
    ready <= 1'b1;
    repeat (3) @(posedge clk);
    check("drained", {9'h0, rvalid}, 10'h000);
    // Terminate after six data bits, then held low gives 8-bit words
    nbits <= 4'h6;
    vin <= 10'($urandom);
    fork
      convert(1, 0, 0);
      begin
        while (!(pcnt == 6 && bco === 1'b0)) @(posedge clk);
        repeat (5) @(posedge clk);
        short_cycle_terminate_n_n <= 1'b0;
      end
    join
    nbits <= 4'h8;
    convert(1, 0, 0);
    short_cycle_terminate_n_n <= 1'b1;
    nbits <= 4'ha;
    convert(1, 0, 0);
    // Bit timing from the link clock
    sel_n <= 1'b1;
    x_run = 1'b1;
    vin <= 10'($urandom);
    repeat (200) @(posedge clk);
    convert(1, 0, 0);
    x_run = 1'b0;
    repeat (200) @(posedge clk);
    print_verdict();
  end
endmodule : tb_sac_sequencer
`default_nettype wire
